// *** logic/fcbu_branch_unit.sv ***
`timescale 1ns/100ps
`include "fcbu_params.svh"

module fcbu_branch_unit
  import fcbu_pkg::*;
#(
  parameter int PC_W = `FCBU_PC_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction byte stream from program memory
  input wire logic [7:0] fetchByte,
  input wire logic fetchValid,
  // Flags of the preceding operation
  input wire logic signFlag,
  input wire logic overflowFlag,
  // Program counter and status
  output logic [PC_W-1:0] progCounter,
  output logic fetchReq,
  output logic branchBusy,
  output logic branchTaken,
  output logic branchDone,
  output logic unknownOpcode
);

  typedef struct packed {
    // Where the sequencer stands
    fcbu_state_t state;
    // Addresses: live pc, collected label, address of the opcode
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] startPc;
    // Decoded opcode, kept for the whole instruction
    logic absForm;
    fcbu_cond_t cond;
    // Registered copies of the status outputs
    logic fetchReq;
    logic busy;
    logic taken;
    logic done;
    logic unknown;
  } fcbu_st_t;

  // Power-on image of the whole state; pc restarts at the reset vector
  localparam fcbu_st_t ST_RESET = '{
    state: FCBU_IDLE,
    pc: PC_W'(`FCBU_PC_RESET),
    target: '0,
    startPc: '0,
    absForm: 1'b0,
    cond: FCBU_C_NEG,
    fetchReq: 1'b0,
    busy: 1'b0,
    taken: 1'b0,
    done: 1'b0,
    unknown: 1'b0
  };

  // State register and its next value
  fcbu_st_t st;
  fcbu_st_t next_st;
  // Flag test handshake with the evaluator
  logic evalStrobe;
  logic condMet;
  // Decode of the byte on the fetch port
  logic isJump;
  logic opAbs;
  fcbu_cond_t opCond;
  // Address arithmetic
  logic [PC_W-1:0] lenPc;
  logic [PC_W-1:0] nextSeqPc;
  logic [PC_W-1:0] offsetExt;
  logic [PC_W-1:0] relTarget;
  logic lastOperand;

  // Flag test sits in its own register so timing is cycle-exact
  // It only updates on the last operand edge, so stale flags never leak in
  fcbu_cond_eval u_cond (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evalStrobe(evalStrobe),
    .cond(st.cond),
    .signFlag(signFlag),
    .overflowFlag(overflowFlag),
    .taken(condMet)
  );

  // Opcode decode of the flag-jump group
  // Any byte outside the group is refused in idle and flagged as unknown
  assign isJump = (fetchByte & `FCBU_GRP_MASK) == `FCBU_GRP_VAL;
  // One bit picks the form, so both forms share a single sequencer
  assign opAbs = fetchByte[`FCBU_ABS_BIT];
  // Low two bits name the flag test directly, no lookup needed
  assign opCond = fcbu_cond_t'(fetchByte[1:0]);

  // Length of the instruction, chosen by form
  assign lenPc = st.absForm ? PC_W'(`FCBU_LEN_ABS) : PC_W'(`FCBU_LEN_REL);
  // Address of the instruction that follows the branch
  assign nextSeqPc = st.startPc + lenPc;
  // Offset byte is signed; widened by copying its top bit
  assign offsetExt = {{(PC_W-8){st.target[7]}}, st.target[7:0]};
  // Relative offset is counted from the following instruction
  assign relTarget = nextSeqPc + offsetExt;

  // Last operand byte: the only edge at which the flags are looked at
  // Sampling later would let the next operation's flags leak in
  assign lastOperand = (st.state == FCBU_OPER1 && !st.absForm)
                     || (st.state == FCBU_OPER2);
  assign evalStrobe = lastOperand && fetchValid;

  // Sequencer: opcode, operand byte(s), execute, done
  // Relative: OPC, OPER1, EXEC = 3 cycles; absolute adds OPER2 = 4 cycles
  // Idle: take an opcode, note where it sits and which test it asks for
  // Oper1: low operand byte, also the whole offset of the relative form
  // Oper2: high operand byte of the absolute form only
  // Exec: fetch is paused for one cycle while the pc is chosen
  // The byte offered during exec is ignored; the source must offer it again
  // Done pulses in the cycle after exec, when idle already takes bytes
  // No stall counter: a missing operand byte simply holds the state
  // Cycle figures therefore hold only when operands come without gaps
  // Flags are only ever read here; nothing in this unit writes them
  // Taken is kept until the next jump opcode so slow readers still see it
  // Unknown bytes still advance the pc, so the stream never stalls
  // Limitation: the high label bits above the pc width are dropped
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.unknown = 1'b0;
    case (st.state)
      FCBU_IDLE: begin
        if (fetchValid) begin
          if (isJump) begin
            // Remember the opcode address: lengths count from it, offsets from the following instruction
            next_st.startPc = st.pc;
            next_st.absForm = opAbs;
            next_st.cond = opCond;
            next_st.busy = 1'b1;
            next_st.taken = 1'b0;
            next_st.state = FCBU_OPER1;
          end else begin
            next_st.unknown = 1'b1;
          end
          // Pc steps over every byte taken, jump or not
          next_st.pc = st.pc + PC_W'(1);
        end
      end
      FCBU_OPER1: begin
        if (fetchValid) begin
          // Low byte lands first; the high part is cleared until oper2
          next_st.target = PC_W'(fetchByte);
          next_st.pc = st.pc + PC_W'(1);
          next_st.state = st.absForm ? FCBU_OPER2 : FCBU_EXEC;
        end
      end
      FCBU_OPER2: begin
        if (fetchValid) begin
          // High byte joins the low one; surplus bits are cut on purpose
          next_st.target = PC_W'({fetchByte, st.target[7:0]});
          next_st.pc = st.pc + PC_W'(1);
          next_st.state = FCBU_EXEC;
        end
      end
      FCBU_EXEC: begin
        // Untaken: continue after the branch; flags are inputs only
        if (condMet && st.absForm) begin
          // Absolute form loads the label address as it stands
          next_st.pc = st.target;
        end else if (condMet) begin
          // Relative form steps from the following instruction
          next_st.pc = relTarget;
        end else begin
          next_st.pc = nextSeqPc;
        end
        // Taken holds until the next jump opcode for status readers
        next_st.taken = condMet;
        next_st.done = 1'b1;
        next_st.busy = 1'b0;
        next_st.state = FCBU_IDLE;
      end
      default: begin
        // Unused codes fall back to idle rather than lock up
        next_st.state = FCBU_IDLE;
        next_st.busy = 1'b0;
      end
    endcase
    // Fetch is paused for the exec cycle, and is low from reset until the first clock
    // Registered so the port has no decode path behind it
    next_st.fetchReq = (next_st.state != FCBU_EXEC);
  end

  // Single state register; async reset loads the power-on image
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // All outputs straight from the state register
  // Program counter as seen by program memory
  assign progCounter = st.pc;
  // Byte request towards program memory
  assign fetchReq = st.fetchReq;
  // Branch status for the rest of the core
  assign branchBusy = st.busy;
  assign branchTaken = st.taken;
  // One-cycle pulses
  assign branchDone = st.done;
  assign unknownOpcode = st.unknown;
  // No output depends on an input in the same cycle

endmodule

// *** logic/fcbu_params.svh ***
`ifndef FCBU_PARAMS_SVH
`define FCBU_PARAMS_SVH

// Program counter width (jump range up to 8 kB)
`define FCBU_PC_W 13
// Reset value of the program counter
`define FCBU_PC_RESET 13'h0000
// Instruction lengths in bytes
`define FCBU_LEN_REL 2'h2
`define FCBU_LEN_ABS 2'h3
// Execution time in clock cycles
`define FCBU_CYC_REL 3'h3
`define FCBU_CYC_ABS 3'h4
// Opcode encodings of the four flag jumps (low two bits select the condition)
`define FCBU_OP_NEG 8'hA0
`define FCBU_OP_OVC 8'hA1
`define FCBU_OP_OVS 8'hA2
`define FCBU_OP_POS 8'hA3
// Opcode bit that selects the absolute form
`define FCBU_ABS_BIT 2
// Opcode field that marks the flag-jump group
`define FCBU_GRP_MASK 8'hF8
`define FCBU_GRP_VAL 8'hA0

`endif

// *** logic/fcbu_pkg.sv ***
package fcbu_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    FCBU_IDLE,
    FCBU_OPER1,
    FCBU_OPER2,
    FCBU_EXEC,
    FCBU_DONE
  } fcbu_state_t;

  // Branch conditions
  typedef enum logic [1:0] {
    FCBU_C_NEG,
    FCBU_C_OVC,
    FCBU_C_OVS,
    FCBU_C_POS
  } fcbu_cond_t;

endpackage

// *** logic/fcbu_cond_eval.sv ***
`timescale 1ns/100ps

// Registered condition test against the flags of the preceding operation
module fcbu_cond_eval
  import fcbu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Evaluation request
  input wire logic evalStrobe,
  input wire fcbu_cond_t cond,
  input wire logic signFlag,
  input wire logic overflowFlag,
  // Result
  output logic taken
);

  typedef struct packed {
    logic taken;
  } fcbu_eval_st_t;

  fcbu_eval_st_t st;
  fcbu_eval_st_t next_st;

  // Result holds until the next evaluation
  always_comb begin
    next_st = st;
    if (evalStrobe) begin
      case (cond)
        FCBU_C_NEG: next_st.taken = signFlag;
        FCBU_C_OVC: next_st.taken = ~overflowFlag;
        FCBU_C_OVS: next_st.taken = overflowFlag;
        FCBU_C_POS: next_st.taken = ~signFlag;
        default: next_st.taken = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign taken = st.taken;

endmodule

// *** bench/fcbu_branch_chk.sv ***
`timescale 1ns/100ps
// Pin-level timing and condition checks on the branch unit
module fcbu_branch_chk #(
  parameter int PC_W = 13
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fetch and flags
  input wire logic [7:0] fetchByte,
  input wire logic fetchValid,
  input wire logic signFlag,
  input wire logic overflowFlag,
  // Results
  input wire logic [PC_W-1:0] progCounter,
  input wire logic fetchReq,
  input wire logic branchBusy,
  input wire logic branchTaken,
  input wire logic branchDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Jump opcode taken in idle; figures assume operands come without stalls
  logic opTake;
  assign opTake = fetchValid && fetchReq && !branchBusy && fetchByte[7:3] == 5'h14;
  a_rel_time: assert property (opTake && !fetchByte[2] |-> ##3 branchDone)
    else $error("relative end off");
  a_abs_time: assert property (opTake && fetchByte[2] |-> ##4 branchDone)
    else $error("absolute end off");
  a_rel_skip: assert property (opTake && !fetchByte[2] ##3 !branchTaken |->
    progCounter == $past(progCounter, 3) + 13'h2) else $error("skip pc wrong");
  a_neg_test: assert property (opTake && fetchByte == 8'hA0 |->
    ##3 branchTaken == $past(signFlag, 2)) else $error("negative test wrong");
  a_ovc_test: assert property (opTake && fetchByte == 8'hA1 |->
    ##3 branchTaken == !$past(overflowFlag, 2)) else $error("ovf clear wrong");
  a_ovs_test: assert property (opTake && fetchByte == 8'hA2 |->
    ##3 branchTaken == $past(overflowFlag, 2)) else $error("ovf set wrong");
  a_pos_test: assert property (opTake && fetchByte == 8'hA3 |->
    ##3 branchTaken == !$past(signFlag, 2)) else $error("positive test wrong");
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  // Row: opcode, operand bytes, flags {sign, ovf, taken}
  typedef struct packed {
    logic [7:0] op, b1, b2;
    logic [2:0] f;
  } fcbu_row_t;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [7:0] fetchByte = 8'h00;
  logic fetchValid = 0, signFlag = 0, overflowFlag = 0;
  logic [12:0] progCounter, pcExp = 13'h0000;
  logic fetchReq, branchBusy, branchTaken, branchDone, unknownOpcode;
  int miscompares = 0, samples_checked = 0, k;
  fcbu_row_t rows [8] = '{'{8'hA0, 8'h04, 8'h00, 3'h5}, '{8'hA1, 8'h08, 8'h00, 3'h1},
    '{8'hA2, 8'hF0, 8'h00, 3'h3}, '{8'hA3, 8'h20, 8'h00, 3'h4},
    '{8'hA4, 8'h00, 8'h00, 3'h0}, '{8'hA5, 8'h00, 8'h00, 3'h2},
    '{8'hA6, 8'h34, 8'h12, 3'h3}, '{8'hA7, 8'h00, 8'h01, 3'h1}};

  fcbu_branch_unit fcbu_branch_unit_i (.ref_clk, .rst_n, .fetchByte, .fetchValid,
    .signFlag, .overflowFlag, .progCounter, .fetchReq, .branchBusy, .branchTaken,
    .branchDone, .unknownOpcode);

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One branch, no stalls; entered on a falling edge, left on the done one
  task automatic branch(input fcbu_row_t r);
    logic [12:0] len;
    len = r.op[2] ? 13'h3 : 13'h2;
    fetchByte = r.op;
    fetchValid = 1;
    signFlag = r.f[2];
    overflowFlag = r.f[1];
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
      if (k == 1) chk(branchBusy, 13'h1);
      if (k == len) chk(fetchReq, 13'h0);
      if (k < len) fetchByte = k == 1 ? r.b1 : r.b2;
      if (k == len) fetchValid = 0;
    end while (k < 8 && branchDone !== 1'h1);
    chk(13'(k), len + 13'h1);
    chk(branchBusy, 13'h0);
    chk(fetchReq, 13'h1);
    chk(branchTaken, r.f[0]);
    pcExp = !r.f[0] ? pcExp + len : r.op[2] ? {r.b2[4:0], r.b1} :
      pcExp + 13'h2 + {{5{r.b1[7]}}, r.b1};
    chk(progCounter, pcExp);
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    chk(progCounter, 13'h0000);
    rst_n = 1;
    repeat (2) @(negedge ref_clk);
    foreach (rows[i]) branch(rows[i]);
    // Foreign byte offered in the done cycle is refused and stepped over
    fetchByte = 8'h5A;
    fetchValid = 1;
    @(negedge ref_clk);
    fetchValid = 0;
    chk(unknownOpcode, 1'h1);
    chk(progCounter, pcExp + 13'h1);
    // Reset in mid-branch must drop the pc and let a fresh branch run
    @(negedge ref_clk);
    fetchByte = 8'hA4;
    fetchValid = 1;
    @(negedge ref_clk);
    rst_n = 0;
    fetchValid = 0;
    @(negedge ref_clk);
    chk(progCounter, 13'h0000);
    chk(branchBusy, 13'h0);
    rst_n = 1;
    repeat (2) @(negedge ref_clk);
    pcExp = 13'h0000;
    branch(rows[0]);
    results;
  end

  // The run needs under 100 cycles; this cuts a hang
  initial begin
    #3000;
    miscompares++;
    results;
  end
endmodule

bind fcbu_branch_unit fcbu_branch_chk #(.PC_W(PC_W)) fcbu_branch_chk_i (.ref_clk,
  .rst_n, .fetchByte, .fetchValid, .signFlag, .overflowFlag, .progCounter, .fetchReq,
  .branchBusy, .branchTaken, .branchDone);
